// [ext_bus_if.sv]
// External bus interface of the signal processor: space selects, strobes,
// wait states, bus hold, flag, branch condition and divided clock output.
// Assumes APB master and core on pclk; all pins pass a two-stage synchroniser.
// Summary of operation
// - Low map pin at reset maps ROM
// - High map pin removes ROM, goes external
// - Pin caught once; software may override
// - Low branch input means true, staged sampling
// - Flag set, cleared, or cleared by load
// - Flag high during reset
// - Output disable tri-states all control pins
// - Only targeted space select low, address valid
// - Hold tri-states selects, strobes, direction
// - Memory strobe low only for memory access
// - I/O strobe low only for I/O access
// - Direction high except during writes
// - Low ready extends access cycle by cycle
// - Ready checked only after two+ waits
// - Hold request claims bus from master
// - Acknowledge only with outputs tri-stated
// - Acknowledge inactive high during reset
// - Wait-done low first wait, high last
// - Fetch indicator low on fetch addresses
// - Clock output half period one to four pclk
// - Divisor four after reset
// - Data and I/O use low sixteen lines
// - Data bus driven only for writes
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module ext_bus_if
    import ext_bus_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [PADDR_W-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire core_req_t            core_req,
    input  wire core_evt_t            core_evt,
    output core_resp_t                core_resp,
    output logic                      branch_condition_true,
    input  wire pin_in_t              pins_in,
    output pin_out_t                  pins_out,
    output pin_oe_t                   pins_oe,
    output logic                      machine_clock_output
);

    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_HOLD} bus_state_t;

    pin_in_t            sync1_reg, sync2_reg;
    bus_state_t         state_reg, state_next;
    core_req_t          acc_reg, acc_next;
    logic [WS_W-1:0]    wcnt_reg, wcnt_next;
    logic [WS_W-1:0]    wait_reg;
    logic [DIV_W-1:0]   div_reg;
    logic               mode_reg;
    logic               init_done_reg;
    logic [1:0]         init_cnt_reg;
    logic               flag_reg, flag_next;
    logic               cond_reg;
    logic [DIV_W:0]     clk_cnt_reg;
    logic               machine_clock_output_reg;
    logic [31:0]        prdata_reg;
    logic               pready_reg, pslverr_reg;
    core_resp_t         resp_reg;
    pin_out_t           pins_reg, pins_next;
    pin_oe_t            oe_reg, oe_next;

    function automatic logic reg_hit(input logic [PADDR_W-1:0] a);
        reg_hit = (a == PMR_OFS) || (a == BANK_SWITCH_CONTROL_REGISTER_OFS) || (a == WAIT_OFS) || (a == STAT_OFS);
    endfunction

    // APB decode
    wire apb_setup    = psel && !penable;
    wire apb_complete = psel && penable && pready_reg;
    wire apb_wr       = apb_complete && pwrite && reg_hit(paddr);
    wire pmr_wr       = apb_wr && (paddr == PMR_OFS);
    wire bank_switch_control_register_wr      = apb_wr && (paddr == BANK_SWITCH_CONTROL_REGISTER_OFS);
    wire wait_wr      = apb_wr && (paddr == WAIT_OFS);

    wire [31:0] status_word = {26'h0, init_done_reg, flag_reg, cond_reg,
                               state_reg == ST_HOLD, state_reg == ST_ACCESS, mode_reg};
    wire [31:0] read_mux =
        (paddr == PMR_OFS)  ? {31'h0, mode_reg} :
        (paddr == BANK_SWITCH_CONTROL_REGISTER_OFS) ? {30'h0, div_reg} :
        (paddr == WAIT_OFS) ? {29'h0, wait_reg} :
        (paddr == STAT_OFS) ? status_word : 32'h0000_0000;

    // Synchronised pin levels
    wire hold_req  = !sync2_reg.hold_request_n;
    wire pins_on   = sync2_reg.output_disable_n;
    wire ready_in  = sync2_reg.ready;

    // ROM hit only in microcomputer mode
    wire rom_hit = (core_req.space == SPACE_PROG) && !mode_reg &&
                   (core_req.addr[LOW_ADDR_W-1:LOW_ADDR_W-2] == ROM_PAGE);
    // no new access while hold is requested
    // Done cycle stays idle: a request still held then is not taken twice
    wire can_take  = (state_reg == ST_IDLE) && core_req.valid && !hold_req && init_done_reg &&
                     !resp_reg.done;
    wire take_rom  = can_take && rom_hit;
    wire take_ext  = can_take && !rom_hit;
    // ready only looked at with two or more waits
    wire ready_chk = wait_reg >= READY_MIN_WS;
    wire waits_done = wcnt_reg >= wait_reg;
    // low ready holds the access one more cycle
    wire acc_finish = (state_reg == ST_ACCESS) && waits_done && !(ready_chk && !ready_in);

    always_comb begin
        state_next = state_reg;
        acc_next   = acc_reg;
        wcnt_next  = wcnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (hold_req) begin
                    state_next = ST_HOLD;
                end else if (take_ext) begin
                    state_next = ST_ACCESS;
                    acc_next   = core_req;
                    wcnt_next  = '0;
                end
            end
            ST_ACCESS: begin
                if (acc_finish) begin
                    state_next = ST_IDLE;
                end else if (!waits_done) begin
                    wcnt_next = wcnt_reg + 3'h1;
                end
            end
            ST_HOLD: begin
                if (!hold_req) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    wire in_acc   = state_next == ST_ACCESS;
    wire in_hold  = state_next == ST_HOLD;
    wire is_io    = acc_next.space == SPACE_IO;

    // set wins over a clear in the same cycle
    assign flag_next = core_evt.set_status_bit_instr ? 1'b1 :
                       (core_evt.clear_status_bit_instr || core_evt.load_status_register_one)
                       ? 1'b0 : flag_reg;

    always_comb begin
        pins_next = pins_reg;
        pins_next.external_flag_output = flag_next;
        // one select low, only during the access
        pins_next.data_space_select_n    = !(in_acc && acc_next.space == SPACE_DATA);
        pins_next.program_space_select_n = !(in_acc && acc_next.space == SPACE_PROG);
        pins_next.io_space_select_n      = !(in_acc && is_io);
        pins_next.memory_strobe_n   = !(in_acc && !is_io);
        pins_next.io_space_strobe_n = !(in_acc && is_io);
        pins_next.read_not_write = !(in_acc && acc_next.write);
        // acknowledge tied to the hold state
        pins_next.bus_release_ack_n = !in_hold;
        // low from first wait up to the last
        pins_next.wait_sequence_done_n = !(in_acc && ready_chk && wcnt_next >= 3'h1 &&
                                           wcnt_next < wait_reg);
        pins_next.instr_fetch_indicator_n = !(in_acc && acc_next.fetch);
        if (in_acc) begin
            // upper lines only for program space
            pins_next.external_address_bus = (acc_next.space == SPACE_PROG) ? acc_next.addr :
                {7'h00, acc_next.addr[LOW_ADDR_W-1:0]};
            pins_next.external_data_bus = acc_next.wdata;
        end
    end

    always_comb begin
        // output disable floats everything but machine_clock_output
        oe_next.flag       = pins_on;
        oe_next.ack        = pins_on;
        oe_next.wait_done  = pins_on;
        oe_next.fetch      = pins_on;
        oe_next.space_ctrl = pins_on && !in_hold;
        oe_next.addr       = pins_on && !in_hold;
        oe_next.data       = pins_on && in_acc && acc_next.write;
    end

    // Pin synchroniser; first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= PIN_IN_RST;
            sync2_reg <= PIN_IN_RST;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            acc_reg   <= '0;
            wcnt_reg  <= '0;
        end else begin
            state_reg <= state_next;
            acc_reg   <= acc_next;
            wcnt_reg  <= wcnt_next;
        end
    end

    // flag high, acknowledge inactive during reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_reg <= '{external_flag_output: 1'b1, data_space_select_n: 1'b1,
                          program_space_select_n: 1'b1, io_space_select_n: 1'b1,
                          memory_strobe_n: 1'b1, io_space_strobe_n: 1'b1,
                          read_not_write: 1'b1, bus_release_ack_n: 1'b1,
                          wait_sequence_done_n: 1'b1, instr_fetch_indicator_n: 1'b1,
                          default: '0};
            oe_reg   <= '{data: 1'b0, default: 1'b1};
            flag_reg <= 1'b1;
        end else begin
            pins_reg <= pins_next;
            oe_reg   <= oe_next;
            flag_reg <= flag_next;
        end
    end

    // map pin caught once the synchroniser has filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_reg  <= '0;
            init_done_reg <= 1'b0;
            mode_reg      <= 1'b0;
        end else if (!init_done_reg) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
            if (init_cnt_reg == INIT_CYCLES) begin
                init_done_reg <= 1'b1;
                mode_reg      <= sync2_reg.rom_map_select;
            end
        end else if (pmr_wr) begin
            mode_reg <= pwdata[PMR_MODE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= BANK_SWITCH_CONTROL_REGISTER_DIV_RST;
            wait_reg <= WAIT_RST;
        end else begin
            if (bank_switch_control_register_wr) begin
                div_reg <= pwdata[BANK_SWITCH_CONTROL_REGISTER_DIV_LSB +: DIV_W];
            end
            if (wait_wr) begin
                wait_reg <= pwdata[WS_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_reg <= 1'b0;
        end else if (core_evt.conditional_execute_decode || core_evt.read_stage) begin
            cond_reg <= !sync2_reg.branch_condition_input_n;
        end
    end

    // machine cycle is two half periods; half period is divisor pclk
    wire [DIV_W:0] half_last = {1'b0, div_reg};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cnt_reg <= '0;
            machine_clock_output_reg  <= 1'b0;
        end else if (clk_cnt_reg >= half_last) begin
            clk_cnt_reg <= '0;
            machine_clock_output_reg  <= !machine_clock_output_reg;
        end else begin
            clk_cnt_reg <= clk_cnt_reg + 3'h1;
        end
    end

    // Registered answer: pready rises in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
            if (apb_setup) begin
                prdata_reg  <= read_mux;
                pslverr_reg <= !reg_hit(paddr);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_reg <= '0;
        end else begin
            resp_reg.done    <= take_rom || acc_finish;
            resp_reg.rom_hit <= take_rom;
            if (acc_finish) begin
                resp_reg.rdata <= sync2_reg.external_data_bus;
            end else if (take_rom) begin
                resp_reg.rdata <= '0;
            end
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign core_resp             = resp_reg;
    assign branch_condition_true = cond_reg;
    assign pins_out              = pins_reg;
    assign pins_oe               = oe_reg;
    assign machine_clock_output  = machine_clock_output_reg;

    sequence s_access_start;
        state_reg == ST_IDLE && take_ext;
    endsequence

    sequence s_first_wait;
        state_reg == ST_ACCESS && wcnt_reg == 3'h1 && ready_chk;
    endsequence

    property p_rom_capture;
        @(posedge pclk) disable iff (!presetn)
        $rose(init_done_reg) |-> mode_reg == $past(sync2_reg.rom_map_select);
    endproperty
    a_rom_capture: assert property (p_rom_capture) else $error("mode not captured");

    property p_mode_kept;
        @(posedge pclk) disable iff (!presetn)
        $past(init_done_reg) && !$past(pmr_wr) |-> $stable(mode_reg);
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("mode changed alone");

    property p_cond;
        @(posedge pclk) disable iff (!presetn)
        core_evt.read_stage |=> cond_reg == !$past(sync2_reg.branch_condition_input_n);
    endproperty
    a_cond: assert property (p_cond) else $error("branch condition wrong");

    property p_flag;
        @(posedge pclk) disable iff (!presetn)
        core_evt.clear_status_bit_instr && !core_evt.set_status_bit_instr
        |=> !pins_reg.external_flag_output;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not cleared");

    property p_disable;
        @(posedge pclk) disable iff (!presetn)
        !pins_on |=> !oe_reg.flag && !oe_reg.space_ctrl && !oe_reg.ack && !oe_reg.data;
    endproperty
    a_disable: assert property (p_disable) else $error("pins driven while disabled");

    property p_exclusive;
        @(posedge pclk) disable iff (!presetn)
        $onehot0({!pins_reg.data_space_select_n, !pins_reg.program_space_select_n,
                  !pins_reg.io_space_select_n}) &&
        !(!pins_reg.memory_strobe_n && !pins_reg.io_space_strobe_n);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("two selects low");

    property p_hold_float;
        @(posedge pclk) disable iff (!presetn)
        !pins_reg.bus_release_ack_n |-> !oe_reg.space_ctrl && !oe_reg.addr && !oe_reg.data;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("ack with bus driven");

    property p_waits;
        @(posedge pclk) disable iff (!presetn)
        s_access_start ##1 (wait_reg == 3'h2 && ready_in) [*3] |-> !pins_reg.memory_strobe_n ||
        !pins_reg.io_space_strobe_n;
    endproperty
    a_waits: assert property (p_waits) else $error("access ended before waits");

    property p_ready_extend;
        @(posedge pclk) disable iff (!presetn)
        state_reg == ST_ACCESS && waits_done && ready_chk && !ready_in |=>
        !pins_reg.memory_strobe_n || !pins_reg.io_space_strobe_n;
    endproperty
    a_ready_extend: assert property (p_ready_extend) else $error("ready ignored");

    property p_wait_done;
        @(posedge pclk) disable iff (!presetn)
        s_first_wait |-> !pins_reg.wait_sequence_done_n;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("wait-done not low");

    property p_data_write;
        @(posedge pclk) disable iff (!presetn)
        oe_reg.data |-> !pins_reg.read_not_write && pins_reg.bus_release_ack_n;
    endproperty
    a_data_write: assert property (p_data_write) else $error("data driven on read");

endmodule

// [ext_bus_pkg.sv]
// Constants, register map and carrier types for the external bus interface.
// Assumes one 25 MHz clock and an APB master in the same domain.
package ext_bus_pkg;

    localparam int ADDR_W     = 23;
    localparam int LOW_ADDR_W = 16;
    localparam int DATA_W     = 16;
    localparam int WS_W       = 3;
    localparam int DIV_W      = 2;
    localparam int PADDR_W    = 12;

    // Register byte offsets
    localparam logic [PADDR_W-1:0] PMR_OFS  = 12'h000;
    localparam logic [PADDR_W-1:0] BANK_SWITCH_CONTROL_REGISTER_OFS = 12'h004;
    localparam logic [PADDR_W-1:0] WAIT_OFS = 12'h008;
    localparam logic [PADDR_W-1:0] STAT_OFS = 12'h00C;

    // Field positions and reset values
    localparam int             PMR_MODE_BIT   = 0;
    localparam int             BANK_SWITCH_CONTROL_REGISTER_DIV_LSB   = 0;
    localparam logic [DIV_W-1:0] BANK_SWITCH_CONTROL_REGISTER_DIV_RST = 2'h3;
    localparam logic [WS_W-1:0]  WAIT_RST     = 3'h7;

    // Internal ROM sits in the top 16K words: address bits 15:14 all ones
    localparam logic [1:0]      ROM_PAGE      = 2'h3;
    localparam logic [WS_W-1:0] READY_MIN_WS  = 3'h2;
    localparam logic [1:0]      INIT_CYCLES   = 2'h2;

    typedef enum logic [1:0] {SPACE_DATA, SPACE_PROG, SPACE_IO} space_t;

    typedef struct packed {
        logic                valid;
        space_t              space;
        logic                write;
        logic                fetch;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } core_req_t;

    typedef struct packed {
        logic set_status_bit_instr;
        logic clear_status_bit_instr;
        logic load_status_register_one;
        logic conditional_execute_decode;
        logic read_stage;
    } core_evt_t;

    typedef struct packed {
        logic              done;
        logic              rom_hit;
        logic [DATA_W-1:0] rdata;
    } core_resp_t;

    typedef struct packed {
        logic              rom_map_select;
        logic              branch_condition_input_n;
        logic              ready;
        logic              hold_request_n;
        logic              output_disable_n;
        logic [DATA_W-1:0] external_data_bus;
    } pin_in_t;

    localparam pin_in_t PIN_IN_RST = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};

    typedef struct packed {
        logic              external_flag_output;
        logic              data_space_select_n;
        logic              program_space_select_n;
        logic              io_space_select_n;
        logic              memory_strobe_n;
        logic              io_space_strobe_n;
        logic              read_not_write;
        logic              bus_release_ack_n;
        logic              wait_sequence_done_n;
        logic              instr_fetch_indicator_n;
        logic [ADDR_W-1:0] external_address_bus;
        logic [DATA_W-1:0] external_data_bus;
    } pin_out_t;

    typedef struct packed {
        logic flag;
        logic space_ctrl;
        logic ack;
        logic wait_done;
        logic fetch;
        logic addr;
        logic data;
    } pin_oe_t;

endpackage

// [ext_bus_partner.sv]
// External memory model: answers reads, stores writes, stalls READY.
// Assumes the bench resolves the shared data bus from both drivers.
module ext_bus_partner
    import ext_bus_pkg::*;
(
    input  wire logic              pclk,
    input  wire pin_out_t          po,
    input  wire pin_oe_t           oe,
    input  wire logic [3:0]        stall,
    output logic                   ready,
    output logic [DATA_W-1:0]      dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [0:15];
    logic [DATA_W-1:0] junk_reg = 16'h3C96;
    logic [3:0]        cnt_reg = 4'h0;
    wire               active = oe.space_ctrl && !(po.memory_strobe_n && po.io_space_strobe_n);
    wire  [3:0]        idx = po.external_address_bus[3:0];
    assign ready = (stall == 4'hF) ? po.wait_sequence_done_n : !(active && cnt_reg < stall);
    // Idle bus toggles so a stale word never passes
    assign dq = (active && po.read_not_write) ? mem[idx] : junk_reg;
    always @(posedge pclk) begin
        junk_reg <= ~junk_reg;
        cnt_reg <= active ? cnt_reg + 4'h1 : 4'h0;
        if (active && !po.read_not_write) begin
            mem[idx] <= po.external_data_bus;
        end
    end
endmodule

// [ext_bus_if_test.sv]
// Self-checking bench for the external bus interface.
// Assumes ext_bus_pkg, ext_bus_if and ext_bus_partner compiled first.
module ext_bus_if_test
    import ext_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic               pclk = 1'b0, presetn = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0]        pwdata = '0, prdata, rd;
    logic               pready, pslverr, er, hit, ready, branch_condition_true;
    core_req_t          core_req = '0;
    core_evt_t          core_evt = '0;
    core_resp_t         core_resp;
    pin_in_t            pins_in;
    pin_out_t           pins_out;
    pin_oe_t            pins_oe;
    logic               machine_clock_output;
    logic               map_pin = 1'b0, bio_n = 1'b1, hold_n = 1'b1, off_n = 1'b1;
    logic [3:0]         stall = 4'h0;
    logic [DATA_W-1:0]  dq;
    int                 cyc, wd, miscompares = 0, n_compared = 0;
    wire  [7:0]         ctl = {pins_out.data_space_select_n, pins_out.program_space_select_n,
        pins_out.io_space_select_n, pins_out.memory_strobe_n, pins_out.io_space_strobe_n,
        pins_out.read_not_write, pins_oe.data, pins_out.instr_fetch_indicator_n};

    // Device drives the data bus only while its enable is up
    assign pins_in = '{map_pin, bio_n, ready, hold_n, off_n,
                       pins_oe.data ? pins_out.external_data_bus : dq};
    always #20 pclk = ~pclk;

    ext_bus_if u_ext_bus_if (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_evt(core_evt), .core_resp(core_resp),
        .branch_condition_true(branch_condition_true), .pins_in(pins_in),
        .pins_out(pins_out), .pins_oe(pins_oe), .machine_clock_output(machine_clock_output)
    );
    ext_bus_partner u_ext_bus_partner (
        .pclk(pclk), .po(pins_out), .oe(pins_oe), .stall(stall), .ready(ready), .dq(dq)
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] ex);
        n_compared++;
        if (got !== ex) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, ex);
        end
    endtask

    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic rst(input logic m);
        @(posedge pclk) {presetn, map_pin} <= {1'b0, m};
        @(negedge pclk) chk({pins_out.external_flag_output,
            pins_out.bus_release_ack_n, ctl, machine_clock_output}, 11'h7FA);
        @(posedge pclk) presetn <= 1'b1;
        do begin
            apb(1'b0, STAT_OFS, 32'h0);
        end while (rd[5] !== 1'b1);
    endtask

    task automatic acc(input space_t s, input logic w, f, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        logic [30:0] ex;
        ex = {s != SPACE_DATA, s != SPACE_PROG, s != SPACE_IO, s == SPACE_IO,
              s != SPACE_IO, !w, w, !f, (s == SPACE_PROG) ? a : {7'h00, a[15:0]}};
        {cyc, wd} = 64'h0;
        @(posedge pclk) core_req <= '{1'b1, s, w, f, a, d};
        do begin
            @(negedge pclk);
            if (ctl[7:5] !== 3'b111) begin
                cyc++;
                wd += int'(pins_out.wait_sequence_done_n === 1'b0);
                chk({ctl, pins_out.external_address_bus}, ex);
            end
        end while (core_resp.done !== 1'b1);
        hit = core_resp.rom_hit;
        chk(ctl, 8'hFD);
        @(posedge pclk) core_req <= '0;
    endtask

    task automatic rom(input logic [ADDR_W-1:0] a, input int c, input logic h);
        acc(SPACE_PROG, 1'b0, 1'b1, a, 16'h0);
        chk({cyc, 31'h0, hit}, {c, 31'h0, h});
    endtask

    task automatic t_rom;
        apb(1'b0, PMR_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, BANK_SWITCH_CONTROL_REGISTER_OFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, WAIT_OFS, 32'h0);
        chk(rd, 32'h7);
        // Unmapped write is refused
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk({rd, 31'h0, er}, 64'h1);
        rom(23'h40C005, 0, 1'b1);
        acc(SPACE_DATA, 1'b0, 1'b0, 23'h00C005, 16'h0);
        chk({cyc, 31'h0, hit}, {32'd8, 32'h0});
        @(posedge pclk) map_pin <= 1'b1;
        apb(1'b0, PMR_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, PMR_OFS, 32'h1);
        rom(23'h00C005, 8, 1'b0);
        rst(1'b1);
        apb(1'b0, PMR_OFS, 32'h0);
        chk(rd, 32'h1);
        rom(23'h00C005, 8, 1'b0);
        apb(1'b1, PMR_OFS, 32'h0);
        rom(23'h00C005, 0, 1'b1);
    endtask

    task automatic t_bus;
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, WAIT_OFS, 32'(j));
            acc(space_t'(j % 3), 1'b1, 1'b0, ADDR_W'(23'h7F0000 + j), DATA_W'(16'hA5C0 + j));
            chk({cyc, wd}, {j + 1, (j > 1) ? j - 1 : 0});
        end
        for (int j = 0; j < 3; j++) begin
            acc(space_t'(j), 1'b0, j == 1, ADDR_W'(23'h7F0000 + j), 16'h0);
            chk(core_resp.rdata, 16'hA5C0 + j);
        end
    endtask

    task automatic t_ready;
        apb(1'b1, WAIT_OFS, 32'h2);
        stall <= 4'h6;
        acc(SPACE_DATA, 1'b0, 1'b0, 23'h1, 16'h0);
        chk(cyc >= 7 && cyc <= 11, 64'h1);
        apb(1'b1, WAIT_OFS, 32'h1);
        acc(SPACE_DATA, 1'b0, 1'b0, 23'h1, 16'h0);
        chk(cyc, 2);
        apb(1'b1, WAIT_OFS, 32'h3);
        stall <= 4'hF;
        acc(SPACE_DATA, 1'b0, 1'b0, 23'h1, 16'h0);
        chk(cyc > 4, 64'h1);
        stall <= 4'h0;
    endtask

    task automatic t_hold;
        int n = 0;
        @(posedge pclk) hold_n <= 1'b0;
        repeat (6) @(posedge pclk);
        @(negedge pclk) chk({pins_out.bus_release_ack_n, pins_oe.ack,
            pins_oe.space_ctrl, pins_oe.addr, pins_oe.data}, 5'b01000);
        @(posedge pclk) core_req <= '{1'b1, SPACE_DATA, 1'b0, 1'b0, 23'h2, 16'h0};
        repeat (8) @(posedge pclk) n += int'(core_resp.done === 1'b1);
        chk(n, 0);
        hold_n <= 1'b1;
        n = 0;
        while (core_resp.done !== 1'b1 && n < 30) begin
            @(negedge pclk);
            n++;
        end
        chk({core_resp.done, pins_out.bus_release_ack_n}, 2'b11);
        @(posedge pclk) core_req <= '0;
        off_n <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk) chk(pins_oe[6:1], 6'h00);
        @(posedge pclk) off_n <= 1'b1;
    endtask

    task automatic ev(input core_evt_t e, input logic pin, input logic [1:0] ex);
        @(posedge pclk) bio_n <= pin;
        repeat (3) @(posedge pclk);
        core_evt <= e;
        @(posedge pclk) core_evt <= '0;
        @(negedge pclk) chk({pins_out.external_flag_output, branch_condition_true}, ex);
    endtask

    task automatic t_flag;
        ev(5'b01001, 1'b0, 2'b01);
        ev(5'b10000, 1'b1, 2'b11);
        ev(5'b00110, 1'b1, 2'b00);
        ev(5'b11010, 1'b0, 2'b11);
    endtask

    task automatic t_clk;
        int hi;
        for (int dv = 4; dv > 0; dv--) begin
            if (dv < 4) apb(1'b1, BANK_SWITCH_CONTROL_REGISTER_OFS, 32'(dv - 1));
            // First periods may straddle the divisor change
            repeat (3) begin
                hi = 0;
                while (machine_clock_output !== 1'b1 && hi < 20) begin
                    @(negedge pclk);
                    hi++;
                end
                hi = 0;
                while (machine_clock_output === 1'b1 && hi < 20) begin
                    @(negedge pclk);
                    hi++;
                end
            end
            chk(hi, dv);
        end
    endtask

    task automatic summarize;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst(1'b0);
        t_rom;
        t_bus;
        t_ready;
        t_hold;
        t_flag;
        t_clk;
        summarize;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        summarize;
    end
endmodule
